// *** verilog/swc_sleep_wake.v ***
// Sleep entry and wake-up control with AHB-Lite register slave
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "swc_regs.vh"
module swc_sleep_wake #(
   parameter WDT_LIMIT  = `SWC_WDT_DEFAULT,
   parameter DRT_CYCLES = `SWC_DRT_CYCLES,
   parameter PIN_W      = 3
) (
   input  wire             hclk,
   input  wire             hresetn,
   input  wire             hsel,
   input  wire [31:0]      haddr,
   input  wire [1:0]       htrans,
   input  wire             hwrite,
   input  wire [2:0]       hsize,
   input  wire [31:0]      hwdata,
   input  wire             hready,
   output reg  [31:0]      hrdata,
   output wire             hreadyout,
   output wire             hresp,
   input  wire             sleep_instr,
   input  wire             clrwdt_instr,
   input  wire             port_access,
   input  wire [PIN_W-1:0] port_pins,
   input  wire             comparator_out,
   input  wire             external_reset_pin_n,
   input  wire [PIN_W-1:0] port_out_in,
   input  wire [PIN_W-1:0] port_oe_in,
   output reg  [PIN_W-1:0] port_out,
   output reg  [PIN_W-1:0] port_oe,
   output wire             osc_driver_en,
   output wire             cpu_reset,
   output wire             reset_pin_out,
   output wire             reset_pin_oe,
   output reg              wake_pulse,
   output wire             timeout_flag_n,
   output wire             powerdown_flag_n,
   output wire             pin_wake_flag,
   output wire             comparator_wake_flag
);
   // ***********************************
   // Pin synchronisers, three stages
   // ***********************************
   reg [PIN_W+1:0] sync_a;
   reg [PIN_W+1:0] sync_b;
   reg [PIN_W+1:0] sync_c;
   reg [PIN_W+1:0] stable;
   wire [PIN_W+1:0] raw_in = {external_reset_pin_n, comparator_out, port_pins};
   genvar gi;
   generate
      for (gi = 0; gi < PIN_W + 2; gi = gi + 1) begin : g_sync
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               sync_a[gi] <= 1'b1;
               sync_b[gi] <= 1'b1;
               sync_c[gi] <= 1'b1;
               stable[gi] <= 1'b1;
            end else begin
               sync_a[gi] <= raw_in[gi];
               sync_b[gi] <= sync_a[gi];
               sync_c[gi] <= sync_b[gi];
               if (sync_b[gi] == sync_c[gi]) begin
                  stable[gi] <= sync_c[gi];
               end
            end
         end
      end
   endgenerate
   wire [PIN_W-1:0] pins_s = stable[PIN_W-1:0];
   wire             cmp_s  = stable[PIN_W];
   wire             rst_s_n = stable[PIN_W+1];

   // ***********************************
   // Control register and bus slave
   // ***********************************
   reg  [3:0]  ctrl;
   reg         ph_write;
   reg  [11:0] ph_addr;
   reg         asleep;
   reg         to_n;
   reg         pd_n;
   reg         pin_flag;
   reg         cmp_flag;
   reg  [19:0] wdt_cnt;
   reg  [PIN_W-1:0] pin_latch;
   reg         cmp_latch;
   reg  [15:0] drt_cnt;
   wire wdt_en = ctrl[`SWC_CTRL_WDT_EN];
   wire rst_en = ctrl[`SWC_CTRL_RST_EN];
   wire pin_en = ctrl[`SWC_CTRL_PIN_EN];
   wire cmp_en = ctrl[`SWC_CTRL_CMP_EN];
   wire addr_ok = hsel & hready & htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   function [31:0] rd_mux;
      input [11:0] a;
      begin
         case (a)
            `SWC_ADDR_CTRL:    rd_mux = {28'h0, ctrl};
            `SWC_ADDR_STATUS:  rd_mux = {24'h0, pin_flag, cmp_flag, 1'b0,
                                         to_n, pd_n, 2'b00, asleep};
            `SWC_ADDR_WDT_CNT: rd_mux = {12'h000, wdt_cnt};
            `SWC_ADDR_LATCH:   rd_mux = {{(32-PIN_W-1){1'b0}}, cmp_latch,
                                         pin_latch};
            default:           rd_mux = 32'h0;
         endcase
      end
   endfunction

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_write <= 1'b0;
         ph_addr  <= 12'h000;
         hrdata   <= 32'h0;
      end else begin
         ph_write <= addr_ok & hwrite;
         ph_addr  <= haddr[11:0];
         hrdata   <= (addr_ok & !hwrite) ? rd_mux(haddr[11:0]) : 32'h0;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= `SWC_CTRL_RESET;
      end else if (ph_write && ph_addr == `SWC_ADDR_CTRL) begin
         ctrl <= hwdata[3:0];
      end
   end

   // ***********************************
   // Wake detection
   // ***********************************
   wire wdt_timeout = wdt_en && (wdt_cnt >= WDT_LIMIT[19:0] - 20'h1);
   wire rst_wake    = rst_en && !rst_s_n;
   wire pin_change  = pin_en && (pins_s != pin_latch);
   wire cmp_change  = cmp_en && (cmp_s != cmp_latch);
   wire wake = asleep && (rst_wake || wdt_timeout || pin_change
                          || cmp_change);
   wire sleep_go = sleep_instr && !asleep && (drt_cnt == 16'h0);

   // ***********************************
   // Sleep state and flags
   // ***********************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         asleep     <= 1'b0;
         to_n       <= 1'b1;
         pd_n       <= 1'b1;
         pin_flag   <= 1'b0;
         cmp_flag   <= 1'b0;
         wake_pulse <= 1'b0;
         port_out   <= {PIN_W{1'b0}};
         port_oe    <= {PIN_W{1'b0}};
      end else begin
         wake_pulse <= wake;
         if (sleep_go) begin
            asleep   <= 1'b1;
            to_n     <= 1'b1;
            pd_n     <= 1'b0;
            pin_flag <= 1'b0;
            cmp_flag <= 1'b0;
            port_out <= port_out_in;
            port_oe  <= port_oe_in;
         end else if (wake) begin
            asleep   <= 1'b0;
            pin_flag <= pin_change;
            cmp_flag <= cmp_change;
         end else if (!asleep) begin
            port_out <= port_out_in;
            port_oe  <= port_oe_in;
         end
         if (wdt_timeout) begin
            to_n <= 1'b0;
         end
      end
   end

   // ***********************************
   // Pin latch, updated on port access; comparator latch, updated on every awake cycle
   // ***********************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_latch <= {PIN_W{1'b1}};
         cmp_latch <= 1'b1;
      end else begin
         if (port_access && !asleep) begin
            pin_latch <= pins_s;
         end
         if (!asleep) begin
            cmp_latch <= cmp_s;
         end
      end
   end

   // ***********************************
   // Watchdog counter
   // ***********************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wdt_cnt <= 20'h0;
      end else if (sleep_go || wake || wdt_timeout
                   || clrwdt_instr || !wdt_en) begin
         wdt_cnt <= 20'h0;
      end else begin
         wdt_cnt <= wdt_cnt + 20'h1;
      end
   end

   // ***********************************
   // Device reset timer
   // ***********************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         drt_cnt <= 16'h0;
      end else if (wake || (!asleep && (wdt_timeout || rst_wake))) begin
         drt_cnt <= DRT_CYCLES[15:0];
      end else if (drt_cnt != 16'h0) begin
         drt_cnt <= drt_cnt - 16'h1;
      end
   end

   assign cpu_reset     = (drt_cnt != 16'h0) || rst_wake;
   assign osc_driver_en = !asleep;
   assign reset_pin_out = 1'b0;
   assign reset_pin_oe  = 1'b0;
   assign timeout_flag_n       = to_n;
   assign powerdown_flag_n     = pd_n;
   assign pin_wake_flag        = pin_flag;
   assign comparator_wake_flag = cmp_flag;
endmodule // swc_sleep_wake

// *** verilog/swc_regs.vh ***
// Register offsets, fields, reset values and timing counts for sleep/wake control
`ifndef SWC_REGS_VH
`define SWC_REGS_VH
// ***********************************
// Register map (byte addresses)
// ***********************************
`define SWC_ADDR_CTRL     12'h000
`define SWC_ADDR_STATUS   12'h004
`define SWC_ADDR_WDT_CNT  12'h008
`define SWC_ADDR_LATCH    12'h00c
// ***********************************
// Control register fields
// ***********************************
`define SWC_CTRL_WDT_EN    0
`define SWC_CTRL_RST_EN    1
`define SWC_CTRL_PIN_EN    2
`define SWC_CTRL_CMP_EN    3
`define SWC_CTRL_RESET     4'h0
// ***********************************
// Status register fields
// ***********************************
`define SWC_ST_PIN_WAKE   7
`define SWC_ST_CMP_WAKE   6
`define SWC_ST_TIMEOUT_N  4
`define SWC_ST_PDOWN_N    3
`define SWC_ST_ASLEEP     0
// ***********************************
// Timing
// ***********************************
`define SWC_CLK_MHZ       250
`define SWC_DRT_NS        10000
`define SWC_DRT_CYCLES    ((`SWC_DRT_NS * `SWC_CLK_MHZ) / 1000)
`define SWC_WDT_DEFAULT   20'h44aa0
`endif

// *** verif/swc_far_side.sv ***
// Model of the reset pin, the input pins and the comparator output
`timescale 1ns/1ns
module swc_far_side (
   input  wire       hclk,
   output reg  [2:0] pins,
   output reg        cmp,
   output reg        rst_n
);
   initial begin
      pins = 3'h0;
      cmp = 1'b0;
      rst_n = 1'b1;
   end
   // New levels are driven just after a clock edge
   task drive(input [2:0] p, input c, input r);
   begin
      @(posedge hclk);
      pins <= p;
      cmp <= c;
      rst_n <= r;
   end
   endtask
endmodule // swc_far_side

// *** verif/swc_sleep_wake_assertions.sv ***
// Concurrent checks on the sleep and wake ports
`timescale 1ns/1ns
module swc_sleep_wake_assertions #(
   parameter PIN_W = 3
) (
   input wire             hclk,
   input wire             hresetn,
   input wire             sleep_instr,
   input wire [PIN_W-1:0] port_out,
   input wire [PIN_W-1:0] port_oe,
   input wire             osc_driver_en,
   input wire             cpu_reset,
   input wire             reset_pin_out,
   input wire             reset_pin_oe,
   input wire             wake_pulse,
   input wire             timeout_flag_n,
   input wire             powerdown_flag_n,
   input wire             pin_wake_flag,
   input wire             comparator_wake_flag
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence s_enter;
      $fell(osc_driver_en);
   endsequence
   sequence s_wake;
      $rose(osc_driver_en);
   endsequence
   chk_sleep_cause: assert property (s_enter |-> $past(sleep_instr) || $past(sleep_instr, 2))
      else $error("sleep entered without sleep strobe");
   chk_sleep_flags: assert property (s_enter |-> !powerdown_flag_n && timeout_flag_n && !pin_wake_flag)
      else $error("flags wrong on sleep entry");
   chk_ports_hold: assert property (!osc_driver_en [*2] |-> $stable(port_out) && $stable(port_oe))
      else $error("port drive moved while asleep");
   chk_pin_quiet: assert property (!reset_pin_oe && !reset_pin_out)
      else $error("reset pin driven");
   chk_wake_pulse: assert property (s_wake |-> ##[0:1] wake_pulse)
      else $error("wake without pulse");
   chk_wake_reset: assert property (s_wake |-> ##[0:2] cpu_reset)
      else $error("wake without device reset");
   chk_reset_hold: assert property ($rose(wake_pulse) |-> cpu_reset [*5])
      else $error("reset timer too short");
   chk_pin_flag: assert property ($rose(pin_wake_flag) |-> s_wake)
      else $error("pin flag set outside wake");
   chk_cmp_flag: assert property ($rose(comparator_wake_flag) |-> s_wake)
      else $error("comparator flag set outside wake");
endmodule // swc_sleep_wake_assertions
bind swc_sleep_wake swc_sleep_wake_assertions #(.PIN_W(PIN_W)) i_chk (
   .hclk, .hresetn, .sleep_instr, .port_out, .port_oe, .osc_driver_en,
   .cpu_reset, .reset_pin_out, .reset_pin_oe, .wake_pulse, .timeout_flag_n,
   .powerdown_flag_n, .pin_wake_flag, .comparator_wake_flag);

// *** verif/tb.sv ***
// Testbench for sleep entry and wake-up control
`timescale 1ns/1ns
`include "swc_regs.vh"
module tb;
   reg         hclk = 1'b0;
   reg         hresetn = 1'b0;
   reg  [31:0] haddr = 32'h0;
   reg  [1:0]  htrans = 2'h0;
   reg         hwrite = 1'b0;
   reg  [31:0] hwdata = 32'h0;
   reg         sleep_instr = 1'b0;
   reg         port_access = 1'b0;
   reg  [2:0]  pout = 3'h5;
   reg  [31:0] rd;
   wire [31:0] hrdata;
   wire [2:0]  pins, port_out, port_oe;
   wire        hready, hresp, cmp, rst_n, osc, cpu_reset, to_n, pd_n;
   wire        pwf, cwf;
   wire [31:0] flg = {28'h0, pwf, cwf, to_n, pd_n};
   integer     fails = 0;
   integer     num_checks = 0;
   integer     cyc = 0;
   always #2 hclk = ~hclk;
   swc_far_side i_far (.hclk, .pins, .cmp, .rst_n);
   swc_sleep_wake #(.WDT_LIMIT(16), .DRT_CYCLES(8)) i_dut (
      .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp,
      .sleep_instr, .clrwdt_instr(1'b0), .port_access, .port_pins(pins),
      .comparator_out(cmp), .external_reset_pin_n(rst_n),
      .port_out_in(pout), .port_oe_in(pout), .port_out, .port_oe,
      .osc_driver_en(osc), .cpu_reset, .reset_pin_out(), .reset_pin_oe(),
      .wake_pulse(), .timeout_flag_n(to_n), .powerdown_flag_n(pd_n),
      .pin_wake_flag(pwf), .comparator_wake_flag(cwf));
   task chk(input [31:0] got, input [31:0] exp);
   begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task bus(input [31:0] a, input w, input [31:0] d);
   begin
      @(posedge hclk);
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (!hready);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (!hready);
      rd = hrdata;
   end
   endtask
   task pulse_access;
   begin
      @(posedge hclk);
      port_access <= 1'b1;
      @(posedge hclk);
      port_access <= 1'b0;
   end
   endtask
   task nap;
   begin
      @(posedge hclk);
      while (cpu_reset !== 1'b0) @(posedge hclk);
      sleep_instr <= 1'b1;
      @(posedge hclk);
      sleep_instr <= 1'b0;
      repeat (3) @(posedge hclk);
   end
   endtask
   task woke;
   begin
      repeat (40) if (osc !== 1'b1) @(posedge hclk);
      @(posedge hclk);
      chk(osc, 1);
      chk(cpu_reset, 1);
   end
   endtask
   task report_and_stop;
   begin
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails = fails + 1;
         report_and_stop;
      end
   end
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      bus(`SWC_ADDR_STATUS, 0, 0);
      chk(rd, 32'h18);
      chk(hresp, 0);
      bus(32'h10, 0, 0);
      chk(rd, 32'h0);
      bus(`SWC_ADDR_CTRL, 1, 32'he);
      bus(`SWC_ADDR_CTRL, 0, 0);
      chk(rd, 32'he);
      pulse_access;
      nap;
      chk(osc, 0);
      chk(flg, 32'h2);
      @(posedge hclk);
      pout <= 3'h2;
      repeat (3) @(posedge hclk);
      chk(port_out, 32'h5);
      chk(port_oe, 32'h5);
      i_far.drive(3'h1, 0, 1);
      woke;
      chk(flg, 32'ha);
      bus(`SWC_ADDR_CTRL, 0, 0);
      chk(rd, 32'he);
      nap;
      woke;
      chk(flg, 32'ha);
      pulse_access;
      nap;
      i_far.drive(3'h1, 1, 1);
      woke;
      chk(flg, 32'h6);
      nap;
      i_far.drive(3'h1, 1, 0);
      woke;
      i_far.drive(3'h1, 1, 1);
      chk(flg, 32'h2);
      bus(`SWC_ADDR_CTRL, 1, 32'h0);
      pulse_access;
      nap;
      i_far.drive(3'h3, 0, 1);
      repeat (20) @(posedge hclk);
      chk(osc, 0);
      bus(`SWC_ADDR_CTRL, 1, 32'h1);
      woke;
      chk(flg, 32'h0);
      report_and_stop;
   end
endmodule // tb
